// ===== dv/gpi_pin_model.sv
// External pad model: drives undriven pins, yields where the device drives
`timescale 1ns/1ps
module gpi_pin_model #(
    parameter int NUM_PINS = 64
) (
    // Device side
    input  wire logic [NUM_PINS-1:0] pinOut,
    input  wire logic [NUM_PINS-1:0] pinOe,
    // Bench level and pad result
    input  wire logic [NUM_PINS-1:0] extLevel,
    output logic      [NUM_PINS-1:0] pinIn
);
    // pad resolution
    // A driven pad shows the device's own data, never the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the GPIO port with pin-interrupt channels
`timescale 1ns/1ps
module tb_top
    import gpi_pkg::*;
;
    localparam int NP = 64;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic [NP-1:0]     extLevel;
    logic [NP-1:0]     pinIn;
    logic [NP-1:0]     pinOut;
    logic [NP-1:0]     pinOe;
    logic              irq;
    int                error_cnt = 0;
    int                compares = 0;
    int                seed = 32'h24c20065;
    logic [31:0]       shadow [2];
    logic [31:0]       v;
    logic [7:0]        b;

    always #25 clk = ~clk;

    gpi_port_irq #(.NUM_PINS(NP)) uut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
    gpi_pin_model #(.NUM_PINS(NP)) pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

    function automatic logic [11:0] chReg(input int c, input logic [11:0] off);
        return 12'h200 + 12'(c * 64) + off;
    endfunction
    // Plain, set and clear aliases of one control word
    function automatic logic [31:0] alias3(input logic [31:0] old, input logic [31:0] wd, input int k);
        return (k == 0) ? wd : ((k == 1) ? (old | wd) : (old & ~wd));
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        write <= w;
        read <= ~w;
        writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        check(32'(n >= 20), 32'h0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        check(x, exp);
    endtask
    // Covers two sync stages, latch, status and irq lag
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask
    task automatic clrAll;
        for (int c = 0; c < NUM_CHAN; c++) begin
            wr(chReg(c, 12'h010), 32'hffff_ffff);
        end
    endtask
    task automatic edgeStep(input logic [NP-1:0] flip, input logic [31:0] exp);
        extLevel <= extLevel ^ flip;
        settle();
        rchk(chReg(0, 12'h010), exp);
        wr(chReg(0, 12'h010), 32'hffff_ffff);
    endtask

    initial begin
        #2_000_000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        extLevel = '0;
        shadow[0] = RST_ZERO;
        shadow[1] = RST_ZERO;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rchk(12'h000, RST_ZERO);
        rchk(12'h00c, RST_ZERO);
        for (int c = 0; c < NUM_CHAN; c++) begin
            rchk(chReg(c, 12'h018), RST_ASSIGN);
        end
        rchk(12'h7fc, RST_ZERO);
        check({31'h0, irq}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            shadow[i % 2] = alias3(shadow[i % 2], v, (i / 2) % 3);
            wr(12'(12 * (i % 2) + 4 * ((i / 2) % 3)), v);
            rchk(12'(12 * (i % 2)), shadow[i % 2]);
        end
        check(pinOut[31:0], shadow[0]);
        check(pinOe[31:0], shadow[1]);
        // Top byte driven and received at once; the rest random inputs
        wr(12'h00c, 32'hff00_0000);
        wr(12'h018, 32'hff00_0000);
        wr(12'h000, 32'ha500_0000);
        v = $random(seed);
        extLevel[31:0] <= v;
        settle();
        clrAll();
        rchk(12'h024, {8'ha5, v[23:0]});
        rchk(chReg(2, 12'h038), {8'ha5, v[23:0]});
        rchk(chReg(1, 12'h010), {8'ha5, v[23:0]});
        wr(12'h00c, 32'h0);
        wr(12'h018, 32'h0);
        extLevel <= '0;
        settle();
        clrAll();
        rchk(chReg(0, 12'h010), RST_ZERO);
        // Pin 3 masked in, pin 4 masked out, both level active
        wr(chReg(0, 12'h004), 32'h0000_0008);
        wr(12'h404, 32'h0000_0001);
        extLevel[4:3] <= 2'b11;
        settle();
        check({31'h0, irq}, 32'h1);
        rchk(chReg(0, 12'h00c), 32'h0000_0008);
        rchk(12'h400, 32'h0000_0001);
        settle();
        check({31'h0, irq}, 32'h0);
        wr(chReg(0, 12'h010), 32'h0000_0018);
        rchk(chReg(0, 12'h010), 32'h0000_0018);
        extLevel[4:3] <= 2'b00;
        settle();
        clrAll();
        rchk(chReg(0, 12'h00c), RST_ZERO);
        // Rising only, then both edges, on pin 5
        wr(chReg(0, 12'h020), 32'h0000_0020);
        edgeStep(64'h20, 32'h20);
        edgeStep(64'h20, 32'h0);
        wr(chReg(0, 12'h034), 32'h0000_0020);
        edgeStep(64'h20, 32'h20);
        edgeStep(64'h20, 32'h20);
        // Inverted level on pin 6 is active while low
        wr(chReg(0, 12'h02c), 32'h0000_0040);
        settle();
        clrAll();
        rchk(chReg(0, 12'h010), 32'h0000_0040);
        edgeStep(64'h40, 32'h40);
        rchk(chReg(0, 12'h010), RST_ZERO);
        wr(chReg(0, 12'h030), 32'h0000_0040);
        extLevel <= '0;
        settle();
        clrAll();
        // Software raise on every channel
        wr(12'h404, 32'h0000_003f);
        for (int c = 0; c < NUM_CHAN; c++) begin
            wr(chReg(c, 12'h004), 32'h0010_0000);
            wr(chReg(c, 12'h014), 32'h0010_0000);
        end
        settle();
        check({31'h0, irq}, 32'h1);
        rchk(12'h400, 32'h0000_003f);
        settle();
        check({31'h0, irq}, 32'h0);
        rchk(chReg(5, 12'h00c), 32'h0010_0000);
        // Channel 5 takes half port 7; out-of-range slots stay empty
        wr(chReg(5, 12'h018), 32'h0908_0a07);
        b = 8'($random(seed));
        extLevel[63:56] <= b;
        settle();
        clrAll();
        rchk(chReg(5, 12'h038), {24'h0, b});
        rchk(chReg(5, 12'h010), {24'h0, b});
        results();
    end
endmodule

// ===== rtl/gpi_pkg.sv
// Shared constants and types for the GPIO port with pin-interrupt channels
package gpi_pkg;
    // Fixed structure
    localparam int NUM_CHAN    = 6;
    localparam int CHAN_BITS   = 32;
    localparam int HALF_PINS   = 8;
    localparam int PORT_PINS   = 32;
    localparam int ADDR_W      = 12;

    // Address fields: region in [11:9], index in [8:6], register in [5:2]
    localparam logic [2:0] REGION_PORT = 3'h0;
    localparam logic [2:0] REGION_CHAN = 3'h1;
    localparam logic [2:0] REGION_GLOB = 3'h2;

    // Port registers (word index within a 0x40 port block)
    localparam logic [3:0] P_DATA      = 4'h0;  // +1 set, +2 clear
    localparam logic [3:0] P_DIR       = 4'h3;  // +1 set, +2 clear
    localparam logic [3:0] P_INEN      = 4'h6;  // +1 set, +2 clear
    localparam logic [3:0] P_PINLVL    = 4'h9;  // read only

    // Channel registers (word index within a 0x40 channel block)
    localparam logic [3:0] C_MASK      = 4'h0;  // +1 set, +2 clear
    localparam logic [3:0] C_PEND      = 4'h3;  // read only: latch and mask
    localparam logic [3:0] C_LATCH     = 4'h4;  // read, write one clears
    localparam logic [3:0] C_LATSET    = 4'h5;  // write one raises request
    localparam logic [3:0] C_ASSIGN    = 4'h6;  // one byte per half-port slot
    localparam logic [3:0] C_EDGE      = 4'h7;  // +1 set, +2 clear
    localparam logic [3:0] C_INV       = 4'ha;  // +1 set, +2 clear
    localparam logic [3:0] C_BOTH      = 4'hd;  // write
    localparam logic [3:0] C_PINST     = 4'he;  // read only

    // Global registers
    localparam logic [3:0] G_STAT      = 4'h0;  // read clears
    localparam logic [3:0] G_IMASK     = 4'h1;

    // Reset values
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [31:0] RST_ASSIGN = 32'h0302_0100;

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] edgeSel;
        logic [31:0] invert;
        logic [31:0] bothEdge;
        logic [31:0] halfMap;
    } gpi_chan_cfg_t;

    typedef struct packed {
        logic [2:0] region;
        logic [2:0] index;
        logic [3:0] regSel;
    } gpi_addr_t;
endpackage

// ===== rtl/gpi_port_irq.sv
// GPIO ports with six grouped pin-interrupt channels behind an Avalon-MM slave
`timescale 1ns/1ps
module gpi_port_irq
    import gpi_pkg::*;
#(
    parameter int NUM_PINS = 64
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    // Pins
    input  wire logic [NUM_PINS-1:0] pinIn,
    output logic      [NUM_PINS-1:0] pinOut,
    output logic      [NUM_PINS-1:0] pinOe,
    // Interrupt
    output logic                     irq
);
    localparam int NUM_PORT = NUM_PINS / PORT_PINS;
    localparam int NUM_HALF = NUM_PINS / HALF_PINS;

    // channel width limit; the port index field reaches eight ports
    if (NUM_PINS % PORT_PINS != 0 || NUM_PINS < PORT_PINS || NUM_PORT > 8) begin
        $error("NUM_PINS must be a multiple of 32 from 32 to 256");
    end

    logic          [NUM_PINS-1:0] syncA_q, syncB_q;
    logic          [NUM_PINS-1:0] data_q, dir_q, inen_q, rxPin;
    gpi_chan_cfg_t                cfg_q [NUM_CHAN];
    logic          [31:0]         latch_q [NUM_CHAN];
    logic          [31:0]         srcPrev_q [NUM_CHAN];
    logic          [31:0]         src [NUM_CHAN];
    logic          [31:0]         hit [NUM_CHAN];
    logic          [NUM_CHAN-1:0] pend, pendPrev_q, stat_q, imask_q;
    logic          [31:0]         rdData;
    logic                         waitReq_q, wrAcc, rdAcc;
    gpi_addr_t                    adr;

    assign adr   = gpi_addr_t'(address[ADDR_W-1:2]);
    assign wrAcc = write && !waitReq_q;
    assign rdAcc = read && !waitReq_q;

    // Plain write, set alias and clear alias of one register
    function automatic logic [31:0] upd3(input logic [31:0] old, input logic [3:0] sel,
                                         input logic [3:0] base, input logic [31:0] wd);
        upd3 = old;
        if (sel == base)
            upd3 = wd;
        else if (sel == base + 4'h1)
            upd3 = old | wd;
        else if (sel == base + 4'h2)
            upd3 = old & ~wd;
    endfunction

    // One wait cycle per access; the answer edge is the only acting edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            waitReq_q <= 1'b1;
        else
            waitReq_q <= !((read || write) && waitReq_q);
    end
    assign waitrequest = waitReq_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= pinIn;
            syncB_q <= syncA_q;
        end
    end

    assign rxPin = (dir_q & inen_q & data_q) | (~(dir_q & inen_q) & syncB_q);

    // Port registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_q <= '0;
            dir_q  <= '0;
            inen_q <= '0;
        end else if (wrAcc && adr.region == REGION_PORT) begin
            for (int p = 0; p < NUM_PORT; p++) begin
                if (adr.index == 3'(p)) begin
                    // set and clear aliases change chosen outputs only
                    data_q[p*32 +: 32] <= upd3(data_q[p*32 +: 32], adr.regSel, P_DATA, writedata);
                    dir_q[p*32 +: 32]  <= upd3(dir_q[p*32 +: 32], adr.regSel, P_DIR, writedata);
                    inen_q[p*32 +: 32] <= upd3(inen_q[p*32 +: 32], adr.regSel, P_INEN, writedata);
                end
            end
        end
    end
    assign pinOut = data_q;
    assign pinOe  = dir_q;

    // each byte of the assignment picks a half port of eight pins
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            for (int b = 0; b < CHAN_BITS; b++) begin
                automatic int h = int'(cfg_q[c].halfMap[(b/8)*8 +: 8]);
                // taken from the receive path whatever the GPIO setup
                if (h < NUM_HALF)
                    src[c][b] = rxPin[h*8 + b%8] ^ cfg_q[c].invert[b];
                else
                    src[c][b] = 1'b0;
            end
            // level, rising only, or both edges
            // polarity applied through the invert bits above
            hit[c] = (cfg_q[c].edgeSel & ((src[c] & ~srcPrev_q[c]) |
                      (cfg_q[c].bothEdge & ~src[c] & srcPrev_q[c]))) | (~cfg_q[c].edgeSel & src[c]);
            pend[c] = |(latch_q[c] & cfg_q[c].mask);
        end
    end

    // Channel configuration and latches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                cfg_q[c]     <= '{mask: RST_ZERO, edgeSel: RST_ZERO, invert: RST_ZERO,
                                  bothEdge: RST_ZERO, halfMap: RST_ASSIGN};
                latch_q[c]   <= RST_ZERO;
                srcPrev_q[c] <= RST_ZERO;
            end
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                automatic logic sel = wrAcc && adr.region == REGION_CHAN && adr.index == 3'(c);
                automatic logic [31:0] clr = (sel && adr.regSel == C_LATCH) ? writedata : RST_ZERO;
                automatic logic [31:0] swr = (sel && adr.regSel == C_LATSET) ? writedata : RST_ZERO;
                srcPrev_q[c] <= src[c];
                // hardware detection and software raise; set wins over clear
                latch_q[c] <= (latch_q[c] & ~clr) | hit[c] | swr;
                if (sel) begin
                    cfg_q[c].mask    <= upd3(cfg_q[c].mask, adr.regSel, C_MASK, writedata);
                    cfg_q[c].edgeSel <= upd3(cfg_q[c].edgeSel, adr.regSel, C_EDGE, writedata);
                    cfg_q[c].invert  <= upd3(cfg_q[c].invert, adr.regSel, C_INV, writedata);
                    if (adr.regSel == C_ASSIGN)
                        cfg_q[c].halfMap <= writedata;
                    if (adr.regSel == C_BOTH)
                        cfg_q[c].bothEdge <= writedata;
                end
            end
        end
    end

    // Read clears only the reported bits, so an event in the wait cycle survives
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pendPrev_q <= '0;
            stat_q     <= '0;
            imask_q    <= '0;
            irq        <= 1'b0;
        end else begin
            pendPrev_q <= pend;
            stat_q <= ((rdAcc && adr.region == REGION_GLOB && adr.regSel == G_STAT) ?
                       (stat_q & ~readdata[NUM_CHAN-1:0]) : stat_q) | (pend & ~pendPrev_q);
            if (wrAcc && adr.region == REGION_GLOB && adr.regSel == G_IMASK)
                imask_q <= writedata[NUM_CHAN-1:0];
            irq <= |(stat_q & imask_q);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdData = RST_ZERO;
        unique case (adr.region)
            REGION_PORT: begin
                for (int p = 0; p < NUM_PORT; p++) begin
                    if (adr.index == 3'(p)) begin
                        if (adr.regSel == P_DATA)
                            rdData = data_q[p*32 +: 32];
                        else if (adr.regSel == P_DIR)
                            rdData = dir_q[p*32 +: 32];
                        else if (adr.regSel == P_INEN)
                            rdData = inen_q[p*32 +: 32];
                        else if (adr.regSel == P_PINLVL)
                            rdData = rxPin[p*32 +: 32];
                    end
                end
            end
            REGION_CHAN: begin
                for (int c = 0; c < NUM_CHAN; c++) begin
                    if (adr.index == 3'(c)) begin
                        // latch and pin state readable whatever the mask
                        if (adr.regSel == C_MASK)
                            rdData = cfg_q[c].mask;
                        else if (adr.regSel == C_PEND)
                            rdData = latch_q[c] & cfg_q[c].mask;
                        else if (adr.regSel == C_LATCH)
                            rdData = latch_q[c];
                        else if (adr.regSel == C_ASSIGN)
                            rdData = cfg_q[c].halfMap;
                        else if (adr.regSel == C_EDGE)
                            rdData = cfg_q[c].edgeSel;
                        else if (adr.regSel == C_INV)
                            rdData = cfg_q[c].invert;
                        else if (adr.regSel == C_BOTH)
                            rdData = cfg_q[c].bothEdge;
                        else if (adr.regSel == C_PINST)
                            rdData = src[c] ^ cfg_q[c].invert;
                    end
                end
            end
            REGION_GLOB: begin
                if (adr.regSel == G_STAT)
                    rdData = {26'h0, stat_q};
                else if (adr.regSel == G_IMASK)
                    rdData = {26'h0, imask_q};
            end
            default: rdData = RST_ZERO;
        endcase
    end

    // Read data captured on the wait cycle, standing at the answer edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            readdata <= RST_ZERO;
        else if (read && waitReq_q)
            readdata <= rdData;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence portWr_s(logic [3:0] r);
        wrAcc && adr.region == REGION_PORT && adr.index == 3'h0 && adr.regSel == r;
    endsequence

    sequence chan0Wr_s(logic [3:0] r);
        wrAcc && adr.region == REGION_CHAN && adr.index == 3'h0 && adr.regSel == r;
    endsequence

    sequence statRd_s;
        rdAcc && adr.region == REGION_GLOB && adr.regSel == G_STAT;
    endsequence

    sync_delay_a: assert property ($past(reset_n, 2) |-> syncB_q == $past(pinIn, 2))
        else $error("synchroniser delay is not two cycles");
    loop_back_a: assert property (dir_q[31] && inen_q[31] |-> rxPin[31] == data_q[31])
        else $error("loopback data missing");
    rx_free_a: assert property (!dir_q[0] |-> rxPin[0] == syncB_q[0])
        else $error("receive path depends on input enable");
    dir_set_a: assert property (portWr_s(P_DIR + 4'h1)
        |=> dir_q[31:0] == ($past(dir_q[31:0]) | $past(writedata)))
        else $error("direction set alias wrong");
    data_clr_a: assert property (portWr_s(P_DATA + 4'h2)
        |=> data_q[31:0] == ($past(data_q[31:0]) & ~$past(writedata)))
        else $error("output clear alias touched other pins");
    mask_set_a: assert property (chan0Wr_s(C_MASK + 4'h1)
        |=> cfg_q[0].mask == ($past(cfg_q[0].mask) | $past(writedata)))
        else $error("mask set alias wrong");
    level_latch_a: assert property (!cfg_q[0].edgeSel[0] && src[0][0] |=> latch_q[0][0])
        else $error("level request not latched");
    rise_latch_a: assert property (cfg_q[0].edgeSel[5] && src[0][5] && !srcPrev_q[0][5] |=> latch_q[0][5])
        else $error("edge request not latched");
    fall_only_a: assert property (cfg_q[0].edgeSel[5] && !cfg_q[0].bothEdge[5] && !latch_q[0][5]
        && !src[0][5] && srcPrev_q[0][5] && !(wrAcc && adr.regSel == C_LATSET) |=> !latch_q[0][5])
        else $error("falling edge latched in rising-only mode");
    both_edge_a: assert property (cfg_q[0].edgeSel[5] && cfg_q[0].bothEdge[5]
        && !src[0][5] && srcPrev_q[0][5] |=> latch_q[0][5])
        else $error("falling edge missed in both-edge mode");
    sw_raise_a: assert property (chan0Wr_s(C_LATSET) ##0 writedata[20] |=> latch_q[0][20])
        else $error("software request not raised");
    masked_read_a: assert property (read && waitReq_q && adr.region == REGION_CHAN && adr.index == 3'h0
        && adr.regSel == C_LATCH |=> readdata == $past(latch_q[0]))
        else $error("latch not readable");
    irq_level_a: assert property ((stat_q & imask_q) != '0 |=> irq)
        else $error("interrupt output missing");
    irq_low_a: assert property ((stat_q & imask_q) == '0 |=> !irq)
        else $error("interrupt output without unmasked status");
    stat_set_a: assert property ((pend & ~pendPrev_q) != '0
        |=> (stat_q & $past(pend & ~pendPrev_q)) == $past(pend & ~pendPrev_q))
        else $error("channel status event lost");
    stat_keep_a: assert property (statRd_s
        |=> (stat_q & $past(stat_q & ~readdata[NUM_CHAN-1:0])) == $past(stat_q & ~readdata[NUM_CHAN-1:0]))
        else $error("status read cleared an unreported event");
    bus_answer_a: assert property ((read || write) && waitReq_q |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not after one wait cycle");
    bus_idle_a: assert property (!(read || write) |=> waitrequest)
        else $error("bus answered with no request");
endmodule
